// ### rtl/sfp_pkg.sv
// package: constants and state types of the serial flash pin front end
package sfp_pkg;

   // -------------------------------------------------------------
   // widths and counts
   // -------------------------------------------------------------
   localparam int          BYTE_W      = 8;
   localparam int          RX_W        = 9;
   localparam int          CMD_FLAG    = 8;
   localparam logic [2:0]  BIT_FIRST   = 3'h0;
   localparam logic [2:0]  BIT_LAST    = 3'h7;
   localparam logic [3:0]  STEPS_NONE  = 4'h0;
   localparam logic [3:0]  STEPS_ONE   = 4'h1;
   localparam logic [3:0]  STEPS_SGL   = 4'h8;
   localparam logic [3:0]  STEPS_DUAL  = 4'h4;
   localparam int          LANE1_BIT   = 7;
   localparam int          LANE0_BIT   = 6;

   // -------------------------------------------------------------
   // power state of the front end
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      SFP_STANDBY,
      SFP_ACTIVE,
      SFP_DRAIN
   } sfp_pwr_t;

   // rising-edge frame state
   typedef struct packed {
      logic [2:0]        bit_cnt;
      logic [BYTE_W-1:0] sr;
      logic              cmd_done;
   } sfp_rise_t;

   // falling-edge frame state
   typedef struct packed {
      logic [3:0]        left;
      logic [BYTE_W-1:0] sr;
      logic              dual_l;
      logic              lane1;
      logic              lane0;
   } sfp_fall_t;

   // system clock state
   typedef struct packed {
      logic              cs_s1;
      logic              cs_s2;
      logic              hold_s1;
      logic              hold_s2;
      logic              rx_s1;
      logic              rx_s2;
      logic              rx_s3;
      logic              take_s1;
      logic              take_s2;
      logic              pend;
      logic [RX_W-1:0]   pend_data;
      logic              overrun;
      logic              put;
      logic [BYTE_W-1:0] tx_word;
      logic              tx_ready;
      sfp_pwr_t          state;
      logic              standby;
      logic              selected;
      logic              frame_end;
      logic              paused;
   } sfp_core_t;

endpackage : sfp_pkg

// ### rtl/sfp_stream_if.sv
// interface: valid/ready word stream between front end modules
`timescale 1ns/10ps
interface sfp_stream_if #(parameter int W = 9) ();
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : sfp_stream_if

// ### rtl/sfp_buf2.sv
// module: two-entry valid/ready buffer
`timescale 1ns/10ps
module sfp_buf2
   import sfp_pkg::*;
#(
   parameter int W = RX_W
)(
   input  wire logic   i_clk,
   input  wire logic   i_rst,
   input  wire logic   i_ce,
   sfp_stream_if.snk   s_in,
   sfp_stream_if.src   s_out
);

   typedef struct packed {
      logic [W-1:0] e0;
      logic [W-1:0] e1;
      logic         v0;
      logic         v1;
   } sfp_buf_t;

   sfp_buf_t r_reg;
   sfp_buf_t r_next;
   logic     pop;
   logic     push;

   assign pop  = r_reg.v0 && s_out.ready;
   assign push = s_in.valid && !r_reg.v1;

   always_comb
   begin
      r_next = r_reg;
      if (pop)
      begin
         r_next.e0 = r_reg.e1;
         r_next.v0 = r_reg.v1;
         r_next.v1 = 1'b0;
      end
      if (push)
      begin
         if (!r_next.v0)
         begin
            r_next.e0 = s_in.data;
            r_next.v0 = 1'b1;
         end
         else
         begin
            r_next.e1 = s_in.data;
            r_next.v1 = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         r_reg <= '0;
      else if (i_ce)
         r_reg <= r_next;
   end

   assign s_out.valid = r_reg.v0;
   assign s_out.data  = r_reg.e0;
   assign s_in.ready  = !r_reg.v1;

   // stalled head word holds still
   property p_buf_stall;
      @(posedge i_clk) disable iff (i_rst || !i_ce)
      s_out.valid && !s_out.ready |=> s_out.valid && $stable(s_out.data);
   endproperty
   a_buf_stall: assert property (p_buf_stall) else $error("buffer head changed while stalled");

endmodule : sfp_buf2

// ### rtl/sfp_frontend.sv
// module: serial flash pin front end, link side and system side
// Functional notes
// - works in clock modes 0 and 3: capture on rise, drive on fall.
// - select high deselects; device drops to standby, never deep power-down.
// - while select is high the output lane floats.
// - while select is high input lane bits are ignored.
// - select rise during program or erase waits for completion before standby.
// - command, address and data bits captured on each rising clock edge.
// - output lane changes only on falling edges, one bit per edge single.
// - dual read turns input lane into output, two bits per falling edge.
// - in dual read both lanes device-driven; host drives neither.
// - while pause is low clock and input ignored, output lane floats.
// - pause suspends communication only; running program or erase continues.
`timescale 1ns/10ps
module sfp_frontend
   import sfp_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   input  wire logic              i_ce,
   input  wire logic              i_sck,
   input  wire logic              i_cs_n,
   input  wire logic              i_hold_n,
   input  wire logic              i_dual_lane_zero,
   output logic                   o_dual_lane_zero,
   output logic                   o_dual_lane_zero_oe_n,
   output logic                   o_dual_lane_one,
   output logic                   o_dual_lane_one_oe_n,
   input  wire logic              i_busy,
   input  wire logic              i_dual_mode,
   input  wire logic              i_tx_valid,
   input  wire logic [BYTE_W-1:0] i_tx_data,
   output logic                   o_tx_ready,
   output logic                   o_rx_valid,
   output logic [BYTE_W-1:0]      o_rx_data,
   output logic                   o_rx_cmd,
   input  wire logic              i_rx_ready,
   output logic                   o_selected,
   output logic                   o_standby,
   output logic                   o_paused,
   output logic                   o_frame_end,
   output logic                   o_overrun
);

   // ----------------------------------------------------------------
   // step count decoding used by the falling-edge logic
   // ----------------------------------------------------------------
   function automatic logic [3:0] f_steps(input logic dual);
      f_steps = dual ? STEPS_DUAL : STEPS_SGL;
   endfunction : f_steps

   sfp_rise_t       rr_reg;
   sfp_rise_t       rr_next;
   sfp_fall_t       fr_reg;
   sfp_fall_t       fr_next;
   sfp_core_t       cr_reg;
   sfp_core_t       cr_next;
   logic            accept;
   logic            byte_done;
   logic            rx_tgl_reg;
   logic [RX_W-1:0] rx_hold_reg;
   logic            put_s1_reg;
   logic            put_s2_reg;
   logic            dual_s1_reg;
   logic            dual_s2_reg;
   logic            take_reg;
   logic            take_ev;
   logic            float_req;
   logic            oe1_n_next;
   logic            oe0_n_next;

   sfp_stream_if #(.W(RX_W)) rx_in ();
   sfp_stream_if #(.W(RX_W)) rx_out ();

   // ----------------------------------------------------------------
   // link rising edge: input capture
   // ----------------------------------------------------------------
   // lane zero is only an input while the device is not driving it
   assign accept    = i_hold_n && o_dual_lane_zero_oe_n;
   assign byte_done = accept && (rr_reg.bit_cnt == BIT_LAST);

   always_comb
   begin
      rr_next = rr_reg;
      if (accept)
      begin
         rr_next.sr      = {rr_reg.sr[BYTE_W-2:0], i_dual_lane_zero};
         rr_next.bit_cnt = 3'(rr_reg.bit_cnt + 3'h1);
         if (byte_done)
            rr_next.cmd_done = 1'b1;
      end
   end

   // frame state cleared while deselected
   always_ff @(posedge i_sck or posedge i_cs_n)
   begin
      if (i_cs_n)
         rr_reg <= '0;
      else
         rr_reg <= rr_next;
   end

   // byte handed to system side by toggle
   always_ff @(posedge i_sck or posedge i_rst)
   begin
      if (i_rst)
      begin
         rx_tgl_reg  <= 1'b0;
         rx_hold_reg <= '0;
      end
      else if (byte_done && !i_cs_n)
      begin
         rx_tgl_reg  <= !rx_tgl_reg;
         rx_hold_reg <= {!rr_reg.cmd_done, rr_reg.sr[BYTE_W-2:0], i_dual_lane_zero};
      end
   end

   // ----------------------------------------------------------------
   // link falling edge: output drive
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [BYTE_W-1:0] sr_n;
      sr_n    = fr_reg.sr;
      fr_next = fr_reg;
      take_ev = 1'b0;
      if (i_hold_n)
      begin
         if (fr_reg.left > STEPS_ONE)
         begin
            sr_n         = fr_reg.dual_l ? {fr_reg.sr[BYTE_W-3:0], 2'h0}
                                         : {fr_reg.sr[BYTE_W-2:0], 1'h0};
            fr_next.left = 4'(fr_reg.left - STEPS_ONE);
         end
         else if (put_s2_reg != take_reg)
         begin
            take_ev = 1'b1;
            // words left from an earlier frame are dropped before command ends
            if (rr_reg.cmd_done)
            begin
               sr_n           = cr_reg.tx_word;
               fr_next.dual_l = dual_s2_reg;
               fr_next.left   = f_steps(dual_s2_reg);
            end
            else
               fr_next.left = STEPS_NONE;
         end
         else
            fr_next.left = STEPS_NONE;
         fr_next.sr    = sr_n;
         fr_next.lane1 = sr_n[LANE1_BIT];
         fr_next.lane0 = sr_n[LANE0_BIT];
      end
   end

   assign oe1_n_next = (fr_next.left == STEPS_NONE);
   assign oe0_n_next = !((fr_next.left != STEPS_NONE) && fr_next.dual_l);
   // float at once when deselected or paused
   assign float_req  = i_cs_n || !i_hold_n;

   always_ff @(negedge i_sck or posedge i_cs_n)
   begin
      if (i_cs_n)
         fr_reg <= '0;
      else
         fr_reg <= fr_next;
   end

   always_ff @(negedge i_sck or posedge float_req)
   begin
      if (float_req)
      begin
         o_dual_lane_one_oe_n  <= 1'b1;
         o_dual_lane_zero_oe_n <= 1'b1;
      end
      else
      begin
         o_dual_lane_one_oe_n  <= oe1_n_next;
         o_dual_lane_zero_oe_n <= oe0_n_next;
      end
   end

   assign o_dual_lane_one  = fr_reg.lane1;
   assign o_dual_lane_zero = fr_reg.lane0;

   // word slot crossing into link domain
   always_ff @(negedge i_sck or posedge i_rst)
   begin
      if (i_rst)
      begin
         put_s1_reg  <= 1'b0;
         put_s2_reg  <= 1'b0;
         dual_s1_reg <= 1'b0;
         dual_s2_reg <= 1'b0;
         take_reg    <= 1'b0;
      end
      else
      begin
         put_s1_reg  <= cr_reg.put;
         put_s2_reg  <= put_s1_reg;
         dual_s1_reg <= i_dual_mode;
         dual_s2_reg <= dual_s1_reg;
         if (take_ev && !i_cs_n)
            take_reg <= !take_reg;
      end
   end

   // ----------------------------------------------------------------
   // system clock side
   // ----------------------------------------------------------------
   always_comb
   begin
      cr_next         = cr_reg;
      cr_next.cs_s1   = i_cs_n;
      cr_next.cs_s2   = cr_reg.cs_s1;
      cr_next.hold_s1 = i_hold_n;
      cr_next.hold_s2 = cr_reg.hold_s1;
      cr_next.rx_s1   = rx_tgl_reg;
      cr_next.rx_s2   = cr_reg.rx_s1;
      cr_next.rx_s3   = cr_reg.rx_s2;
      cr_next.take_s1 = take_reg;
      cr_next.take_s2 = cr_reg.take_s1;

      cr_next.selected  = !cr_reg.cs_s2;
      cr_next.frame_end = cr_reg.cs_s2 && cr_reg.selected;
      cr_next.paused    = !cr_reg.cs_s2 && !cr_reg.hold_s2;

      // pending byte into buffer; a new byte still wins over the clear
      if (!cr_reg.cs_s2 && !cr_reg.selected)
         cr_next.overrun = 1'b0;
      if (cr_reg.pend && rx_in.ready)
         cr_next.pend = 1'b0;
      if (cr_reg.rx_s2 != cr_reg.rx_s3)
      begin
         if (cr_next.pend)
            cr_next.overrun = 1'b1;
         cr_next.pend      = 1'b1;
         cr_next.pend_data = rx_hold_reg;
      end

      if (i_tx_valid && cr_reg.tx_ready)
      begin
         cr_next.put     = !cr_reg.put;
         cr_next.tx_word = i_tx_data;
      end
      cr_next.tx_ready = (cr_next.put == cr_reg.take_s2) && !cr_reg.cs_s2;

      // pause and busy are independent; busy alone holds off standby
      case (cr_reg.state)
         SFP_STANDBY:
            if (!cr_reg.cs_s2)
               cr_next.state = SFP_ACTIVE;
         SFP_ACTIVE:
            if (cr_reg.cs_s2)
               cr_next.state = i_busy ? SFP_DRAIN : SFP_STANDBY;
         SFP_DRAIN:
            if (!cr_reg.cs_s2)
               cr_next.state = SFP_ACTIVE;
            else if (!i_busy)
               cr_next.state = SFP_STANDBY;
         default:
            cr_next.state = SFP_STANDBY;
      endcase
      cr_next.standby = (cr_next.state == SFP_STANDBY);
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         cr_reg          <= '0;
         cr_reg.cs_s1    <= 1'b1;
         cr_reg.cs_s2    <= 1'b1;
         cr_reg.hold_s1  <= 1'b1;
         cr_reg.hold_s2  <= 1'b1;
         cr_reg.state    <= SFP_STANDBY;
         cr_reg.standby  <= 1'b1;
      end
      else if (i_ce)
         cr_reg <= cr_next;
   end

   assign rx_in.valid  = cr_reg.pend;
   assign rx_in.data   = cr_reg.pend_data;
   assign rx_out.ready = i_rx_ready;

   sfp_buf2 #(.W(RX_W)) u_rx_buf (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .i_ce  (i_ce),
      .s_in  (rx_in),
      .s_out (rx_out)
   );

   assign o_rx_valid  = rx_out.valid;
   assign o_rx_data   = rx_out.data[BYTE_W-1:0];
   assign o_rx_cmd    = rx_out.data[CMD_FLAG];
   assign o_tx_ready  = cr_reg.tx_ready;
   assign o_selected  = cr_reg.selected;
   assign o_standby   = cr_reg.standby;
   assign o_paused    = cr_reg.paused;
   assign o_frame_end = cr_reg.frame_end;
   assign o_overrun   = cr_reg.overrun;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_bit_taken;
      accept ##1 (rr_reg.bit_cnt != BIT_FIRST);
   endsequence
   property p_capture;
      @(posedge i_sck) disable iff (i_cs_n)
      s_bit_taken |-> rr_reg.sr[0] == $past(i_dual_lane_zero);
   endproperty
   a_capture: assert property (p_capture) else $error("input bit not captured on rise");

   property p_cmd_byte;
      @(posedge i_sck) disable iff (i_cs_n)
      byte_done && !rr_reg.cmd_done |=> (rx_tgl_reg != $past(rx_tgl_reg)) && rx_hold_reg[CMD_FLAG]
         && rx_hold_reg[BYTE_W-1:0] == {$past(rr_reg.sr[BYTE_W-2:0]), $past(i_dual_lane_zero)};
   endproperty
   a_cmd_byte: assert property (p_cmd_byte) else $error("command byte wrong");

   property p_desel_float;
      @(posedge i_clk) disable iff (i_rst)
      i_cs_n |-> o_dual_lane_one_oe_n && o_dual_lane_zero_oe_n;
   endproperty
   a_desel_float: assert property (p_desel_float) else $error("lane driven while deselected");

   property p_hold_float;
      @(posedge i_clk) disable iff (i_rst)
      !i_hold_n |-> o_dual_lane_one_oe_n && o_dual_lane_zero_oe_n;
   endproperty
   a_hold_float: assert property (p_hold_float) else $error("lane driven during pause");

   property p_desel_no_rx;
      @(posedge i_clk) disable iff (i_rst)
      i_cs_n && $past(i_cs_n) |-> $stable(rx_tgl_reg);
   endproperty
   a_desel_no_rx: assert property (p_desel_no_rx) else $error("byte taken while deselected");

   property p_busy_wait;
      @(posedge i_clk) disable iff (i_rst || !i_ce)
      cr_reg.cs_s2 && i_busy |=> !o_standby;
   endproperty
   a_busy_wait: assert property (p_busy_wait) else $error("standby during busy");

   sequence s_idle_desel;
      (cr_reg.cs_s2 && !i_busy)[*2];
   endsequence
   property p_standby;
      @(posedge i_clk) disable iff (i_rst || !i_ce)
      s_idle_desel |=> o_standby && !o_selected;
   endproperty
   a_standby: assert property (p_standby) else $error("no standby after deselect");

   property p_pause_busy;
      @(posedge i_clk) disable iff (i_rst || !i_ce)
      cr_reg.paused |=> !o_standby;
   endproperty
   a_pause_busy: assert property (p_pause_busy) else $error("pause changed power state");

   property p_single_shift;
      @(negedge i_sck) disable iff (i_cs_n || !i_hold_n)
      fr_reg.left > STEPS_ONE && !fr_reg.dual_l |=> o_dual_lane_one == $past(fr_reg.sr[LANE0_BIT]);
   endproperty
   a_single_shift: assert property (p_single_shift) else $error("single bit not shifted");

   property p_dual_pair;
      @(negedge i_sck) disable iff (i_cs_n || !i_hold_n)
      fr_reg.left > STEPS_ONE && fr_reg.dual_l |=>
         {o_dual_lane_one, o_dual_lane_zero} == {$past(fr_reg.sr[5]), $past(fr_reg.sr[4])};
   endproperty
   a_dual_pair: assert property (p_dual_pair) else $error("dual pair order wrong");

   property p_dual_drive;
      @(negedge i_sck) disable iff (i_cs_n || !i_hold_n)
      fr_reg.left > STEPS_ONE && fr_reg.dual_l |=> !o_dual_lane_one_oe_n && !o_dual_lane_zero_oe_n;
   endproperty
   a_dual_drive: assert property (p_dual_drive) else $error("dual lanes not both driven");

endmodule : sfp_frontend

// ### verification/sfp_host_model.sv
// partner model: spi host driving select, clock, pause and lane zero
`timescale 1ns/10ps
module sfp_host_model
(
   output logic      o_sck,
   output logic      o_cs_n,
   output logic      o_hold_n,
   output logic      o_lane_zero,
   input  wire logic i_d0,
   input  wire logic i_d0_oe_n,
   input  wire logic i_d1,
   input  wire logic i_d1_oe_n
);
   logic       si;
   logic       drv;
   logic       mode3;
   logic [7:0] rd_byte;
   int         rd_cnt;

   // released lane toggles every bit, never a stale level
   assign o_lane_zero = (i_d0_oe_n === 1'b0) ? i_d0 : si;

   initial
   begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_hold_n = 1'b1;
      si = 1'b0;
      drv = 1'b1;
      mode3 = 1'b0;
      rd_byte = 8'h00;
      rd_cnt = 0;
   end

   // ------------------------------------------------------------
   // framing
   // ------------------------------------------------------------
   task automatic start(input logic m3);
      mode3 = m3;
      drv = 1'b1;
      o_sck = m3;
      #5.3;
      o_cs_n = 1'b0;
      #3;
   endtask : start

   task automatic stop();
      if (!mode3)
      begin
         o_sck = 1'b0;
         #3;
      end
      o_cs_n = 1'b1;
      drv = 1'b1;
      #6;
   endtask : stop

   // one sck period; read lanes at the rising edge
   task automatic clk_bit(input logic b);
      o_sck = 1'b0;
      si = drv ? b : ~si;
      #3;
      o_sck = 1'b1;
      if (i_d1_oe_n === 1'b0 && rd_cnt < 8)
      begin
         if (drv)
         begin
            rd_byte = {rd_byte[6:0], i_d1};
            rd_cnt = rd_cnt + 1;
         end
         else if (i_d0_oe_n === 1'b0)
         begin
            rd_byte = {rd_byte[5:0], i_d1, i_d0};
            rd_cnt = rd_cnt + 2;
         end
      end
      #3;
   endtask : clk_bit

   task automatic bits(input logic [7:0] v, input int n);
      for (int i = 7; i > 7 - n; i--)
         clk_bit(v[i]);
   endtask : bits

   task automatic read(input int n, input logic dual);
      drv = !dual;
      rd_cnt = 0;
      repeat (n) clk_bit(1'b0);
   endtask : read

   // ------------------------------------------------------------
   // pause
   // ------------------------------------------------------------
   task automatic hold_on(input int n);
      o_sck = 1'b0;
      #3;
      o_hold_n = 1'b0;
      repeat (n)
      begin
         si = 1'b1;
         #3 o_sck = 1'b1;
         #3 o_sck = 1'b0;
      end
   endtask : hold_on

   task automatic hold_off();
      o_hold_n = 1'b1;
      #3;
   endtask : hold_off
endmodule : sfp_host_model

// ### verification/test_serial_flash_pin_frontend.sv
// testbench: serial flash pin front end against the spi host model
`timescale 1ns/10ps
module test_serial_flash_pin_frontend;
   import sfp_pkg::*;
   logic       i_clk, i_rst, i_ce, sck, cs_n, hold_n, lz, o_lz, o_lz_oe_n, o_l1, o_l1_oe_n;
   logic       i_busy, i_dual_mode, i_tx_valid, o_tx_ready, o_rx_valid, o_rx_cmd, i_rx_ready;
   logic       o_selected, o_standby, o_paused, o_frame_end, o_overrun;
   logic [7:0] i_tx_data, o_rx_data;
   logic [8:0] rxq[$];
   int         n_fail, compares, n_fe, cyc;

   sfp_frontend DUT (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_sck(sck), .i_cs_n(cs_n),
      .i_hold_n(hold_n), .i_dual_lane_zero(lz), .o_dual_lane_zero(o_lz), .o_dual_lane_zero_oe_n(o_lz_oe_n),
      .o_dual_lane_one(o_l1), .o_dual_lane_one_oe_n(o_l1_oe_n), .i_busy(i_busy), .i_dual_mode(i_dual_mode),
      .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data), .o_tx_ready(o_tx_ready), .o_rx_valid(o_rx_valid),
      .o_rx_data(o_rx_data), .o_rx_cmd(o_rx_cmd), .i_rx_ready(i_rx_ready), .o_selected(o_selected),
      .o_standby(o_standby), .o_paused(o_paused), .o_frame_end(o_frame_end), .o_overrun(o_overrun));

   sfp_host_model host (.o_sck(sck), .o_cs_n(cs_n), .o_hold_n(hold_n), .o_lane_zero(lz), .i_d0(o_lz),
      .i_d0_oe_n(o_lz_oe_n), .i_d1(o_l1), .i_d1_oe_n(o_l1_oe_n));

   // ------------------------------------------------------------
   // clock, monitors, timeout
   // ------------------------------------------------------------
   always #2 i_clk = ~i_clk;

   always @(posedge i_clk)
   begin
      cyc = cyc + 1;
      if (o_rx_valid === 1'b1 && i_rx_ready === 1'b1)
         rxq.push_back({o_rx_cmd, o_rx_data});
      if (o_frame_end === 1'b1)
         n_fe = n_fe + 1;
      if (cyc == 20000)
      begin
         n_fail = n_fail + 1;
         wrap_up();
      end
   end

   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      compares = compares + 1;
      if (seen !== exp)
      begin
         n_fail = n_fail + 1;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic clks(input int n);
      repeat (n) @(posedge i_clk);
   endtask : clks

   task automatic send_tx(input logic [7:0] v);
      int k;
      i_tx_valid <= 1'b1;
      i_tx_data  <= v;
      for (k = 0; k < 100; k++)
      begin
         @(posedge i_clk);
         if (o_tx_ready === 1'b1)
            break;
      end
      i_tx_valid <= 1'b0;
      check("tx taken", 9'(k < 100), 9'h001);
   endtask : send_tx

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_rx(input logic m3, input logic [7:0] cmd, input logic [7:0] dat);
      int fe0;
      fe0 = n_fe;
      rxq.delete();
      check("lane one float", 9'(o_l1_oe_n), 9'h001);
      check("lane zero float", 9'(o_lz_oe_n), 9'h001);
      host.start(m3);
      clks(5);
      check("selected", 9'(o_selected), 9'h001);
      host.bits(cmd, 8);
      host.bits(dat, 8);
      host.bits(8'hff, 3);
      host.stop();
      clks(12);
      check("rx count", 9'(rxq.size()), 9'h002);
      check("rx cmd", rxq[0], {1'b1, cmd});
      check("rx data", rxq[1], {1'b0, dat});
      check("frame end", 9'(n_fe - fe0), 9'h001);
      check("standby", 9'(o_standby), 9'h001);
      $display("test rx mode %0d done, fails %0d", m3, n_fail);
   endtask : t_rx

   task automatic t_tx(input logic dual, input logic [7:0] v);
      rxq.delete();
      i_dual_mode <= dual;
      host.start(1'b0);
      host.bits(8'h3b, 8);
      clks(12);
      check("cmd seen", rxq[0], 9'h13b);
      send_tx(v);
      host.read(16, dual);
      host.stop();
      clks(4);
      check("tx bits", 9'(host.rd_cnt), 9'h008);
      if (dual)
         check("tx dual", 9'(host.rd_byte), {1'b0, v});
      else
         check("tx single", 9'(host.rd_byte), {1'b0, v});
      check("lanes float", 9'({o_l1_oe_n, o_lz_oe_n}), 9'h003);
      i_dual_mode <= 1'b0;
      $display("test tx dual %0d done, fails %0d", dual, n_fail);
   endtask : t_tx

   task automatic t_pause();
      rxq.delete();
      host.start(1'b0);
      host.bits(8'hc0, 4);
      host.hold_on(5);
      clks(6);
      check("paused", 9'(o_paused), 9'h001);
      check("pause float", 9'(o_l1_oe_n), 9'h001);
      host.hold_off();
      host.bits(8'h90, 4);
      host.stop();
      clks(12);
      check("pause byte", rxq[0], 9'h1c9);
      check("pause count", 9'(rxq.size()), 9'h001);
      $display("test pause done, fails %0d", n_fail);
   endtask : t_pause

   task automatic t_busy();
      host.start(1'b0);
      host.bits(8'h20, 8);
      clks(1);
      i_busy <= 1'b1;
      host.hold_on(2);
      clks(8);
      check("busy paused", 9'(o_standby), 9'h000);
      host.hold_off();
      host.stop();
      clks(20);
      check("drain", 9'(o_standby), 9'h000);
      i_ce <= 1'b0;
      i_busy <= 1'b0;
      clks(4);
      check("frozen", 9'(o_standby), 9'h000);
      i_ce <= 1'b1;
      clks(4);
      check("after drain", 9'(o_standby), 9'h001);
      $display("test busy done, fails %0d", n_fail);
   endtask : t_busy

   task automatic t_overrun();
      rxq.delete();
      i_rx_ready <= 1'b0;
      host.start(1'b0);
      for (int i = 1; i < 5; i++)
         host.bits(8'(i * 17), 8);
      clks(20);
      check("overrun", 9'(o_overrun), 9'h001);
      check("held valid", 9'(o_rx_valid), 9'h001);
      i_rx_ready <= 1'b1;
      clks(10);
      host.stop();
      check("drained", 9'(rxq.size()), 9'h003);
      check("first", rxq[0], 9'h111);
      check("second", rxq[1], 9'h022);
      check("latest", rxq[2], 9'h044);
      $display("test overrun done, fails %0d", n_fail);
   endtask : t_overrun

   task automatic wrap_up();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      {i_clk, i_rst, i_ce, i_busy, i_dual_mode, i_tx_valid, i_rx_ready} = 7'h31;
      i_rst = 1'b1;
      i_tx_data = 8'h00;
      {n_fail, compares, n_fe, cyc} = '0;
      clks(12);
      i_rst <= 1'b0;
      clks(2);
      check("reset standby", 9'(o_standby), 9'h001);
      t_rx(1'b0, 8'ha5, 8'h3c);
      t_rx(1'b1, 8'h5a, 8'hc3);
      t_tx(1'b0, 8'hc6);
      t_tx(1'b1, 8'h9b);
      t_pause();
      t_busy();
      t_overrun();
      wrap_up();
   end
endmodule : test_serial_flash_pin_frontend
